//--- include/ref_select_pkg.sv
// Package: register map, field layout and encodings for reference selection
package ref_select_pkg;

	// Register offsets
	localparam logic [7:0] OFF_MON_SEL = 8'h20;
	localparam logic [7:0] OFF_MODE = 8'h21;
	localparam logic [7:0] OFF_HOLDOFF = 8'h22;
	localparam logic [7:0] OFF_PRESCALE = 8'h23;

	// Field positions in monitor_and_select_config
	localparam int MON_DIV_LSB = 3;
	localparam int IDLE_GATE_BIT = 2;
	localparam int HO_DIS_BIT = 1;
	localparam int SRC_BIT = 0;

	// Field positions in selection_mode_config
	localparam int REVERT_BIT = 4;
	localparam int MODE_LSB = 2;
	localparam int INT_SEL_BIT = 0;

	// Writable bit masks (reserved bits read zero)
	localparam logic [7:0] MASK_MON_SEL = 8'hFF;
	localparam logic [7:0] MASK_MODE = 8'h1D;
	localparam logic [7:0] MASK_HOLDOFF = 8'hFF;
	localparam logic [7:0] MASK_PRESCALE = 8'hC3;

	// Reset values
	localparam logic [7:0] RST_MON_SEL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_HOLDOFF = 8'h80;
	localparam logic [7:0] RST_PRESCALE = 8'h00;

	// Selection mode encodings
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'h0,
		MODE_AUTO = 2'h1,
		MODE_SHORT_HOLD = 2'h2,
		MODE_AUTO_HOLD = 2'h3
	} sel_mode_t;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Decoded configuration handed to the selection logic
	typedef struct packed {
		logic [4:0] mon_div;
		logic idle_gate;
		logic ho_disable;
		logic src_reg;
		logic revert;
		sel_mode_t mode;
		logic int_sel;
	} sel_cfg_t;

endpackage : ref_select_pkg

//--- src/input_reference_select_control.sv
// Input reference selection, gating and monitor prescaler control
//
// Contract
// - monitor compares inputs against divided oscillator
// - divider field: base ratio times power two
// - gate bit blocks the unselected input
// - holdover on manual switch, mode ignored
// - disable bit set: mode field governs
// - source bit zero: pin picks input
// - source bit one: register bit picks
// - mode field encodings, automatic uses state machine
// - select bit picks reference or primary
`timescale 1ns/1ps

module input_reference_select_control (
	input wire logic sys_clk,
	input wire logic rst,
	input ref_select_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic pin_input_pick,
	input wire logic auto_pick,
	input wire logic ref_input_0,
	input wire logic ref_input_1,
	output logic ref_input_0_gated,
	output logic ref_input_1_gated,
	output logic selected_input,
	output logic holdover_active,
	output logic [5:0] monitor_div_ratio,
	output logic monitor_tick,
	output ref_select_pkg::sel_cfg_t sel_cfg,
	output logic [7:0] holdoff_count,
	output logic [1:0] holdoff_prescale,
	output logic [1:0] holdoff_aux
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Decode divider field into ratio: base from top three, shift by low two
	function automatic logic [5:0] div_ratio(input logic [4:0] f);
		logic [2:0] base;
		base = f[4] ? (3'h2 + {1'b0, f[3:2]}) : 3'h1;
		div_ratio = 6'({3'h0, base} << f[1:0]);
	endfunction : div_ratio

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] mon_sel_q; // Monitor divider and selection control
	logic [7:0] mode_q; // Mode, revert and internal select
	logic [7:0] holdoff_q; // Hold-off count
	logic [7:0] prescale_q; // Hold-off prescale
	logic [7:0] rdata_d; // Read mux result

	// Address hits
	wire hit_mon = reg_req.addr == ref_select_pkg::OFF_MON_SEL;
	wire hit_mode = reg_req.addr == ref_select_pkg::OFF_MODE;
	wire hit_hold = reg_req.addr == ref_select_pkg::OFF_HOLDOFF;
	wire hit_pre = reg_req.addr == ref_select_pkg::OFF_PRESCALE;
	wire [7:0] wmasked_mode = reg_req.wdata & ref_select_pkg::MASK_MODE;
	wire [7:0] wmasked_pre = reg_req.wdata & ref_select_pkg::MASK_PRESCALE;

	// Register writes; reserved bits never stored so they read zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mon_sel_q <= ref_select_pkg::RST_MON_SEL;
			mode_q <= ref_select_pkg::RST_MODE;
			holdoff_q <= ref_select_pkg::RST_HOLDOFF;
			prescale_q <= ref_select_pkg::RST_PRESCALE;
		end else if (reg_req.wr) begin
			if (hit_mon) mon_sel_q <= reg_req.wdata;
			if (hit_mode) mode_q <= wmasked_mode;
			if (hit_hold) holdoff_q <= reg_req.wdata;
			if (hit_pre) prescale_q <= wmasked_pre;
		end
	end

	// Read mux; unmapped offsets read zero
	assign rdata_d = hit_mon ? mon_sel_q :
		hit_mode ? mode_q :
		hit_hold ? holdoff_q :
		hit_pre ? prescale_q : 8'h00;

	// Registered read data, valid one cycle after the read strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd) reg_rdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field decode

	assign sel_cfg.mon_div = mon_sel_q[ref_select_pkg::MON_DIV_LSB +: 5];
	assign sel_cfg.idle_gate = mon_sel_q[ref_select_pkg::IDLE_GATE_BIT];
	assign sel_cfg.ho_disable = mon_sel_q[ref_select_pkg::HO_DIS_BIT];
	assign sel_cfg.src_reg = mon_sel_q[ref_select_pkg::SRC_BIT];
	assign sel_cfg.revert = mode_q[ref_select_pkg::REVERT_BIT];
	assign sel_cfg.mode =
		ref_select_pkg::sel_mode_t'(mode_q[ref_select_pkg::MODE_LSB +: 2]);
	assign sel_cfg.int_sel = mode_q[ref_select_pkg::INT_SEL_BIT];
	assign holdoff_count = holdoff_q;
	assign holdoff_prescale = prescale_q[7:6];
	assign holdoff_aux = prescale_q[1:0];

	////////////////////////////////////////////////////////////////////////
	// Monitor prescaler

	logic [5:0] div_cnt_q; // Oscillator cycles in current period
	logic tick_q; // One pulse per divided period
	wire [5:0] ratio = div_ratio(sel_cfg.mon_div);

	assign monitor_div_ratio = ratio;

	// divided oscillator reference tick
	// Counter restarts if ratio shrinks below it, so no long wrap
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_cnt_q <= 6'h00;
			tick_q <= 1'b0;
		end else if (div_cnt_q >= ratio - 6'h01) begin
			div_cnt_q <= 6'h00;
			tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 6'h01;
			tick_q <= 1'b0;
		end
	end
	assign monitor_tick = tick_q;

	////////////////////////////////////////////////////////////////////////
	// Reference selection

	logic sel_q; // Active reference input
	logic manual_pick; // Pin or register choice
	logic auto_mode; // Automatic mode in force
	logic hold_q; // Holdover flag
	logic sel_d;
	logic hold_d;

	// pin picks when source bit clear
	// register bit picks when source bit set
	assign manual_pick = sel_cfg.src_reg ? sel_cfg.int_sel : pin_input_pick;

	// mode field ignored while disable bit clear
	assign auto_mode = sel_cfg.ho_disable & sel_cfg.mode[0];

	// Next selection and holdover state
	always_comb begin
		sel_d = sel_q;
		hold_d = hold_q;
		if (auto_mode) begin
			// state machine picks, primary via select bit
			sel_d = auto_pick;
			hold_d = 1'b0;
		end else if (manual_pick != sel_q) begin
			sel_d = manual_pick;
			// short-term holdover code holds, plain manual not
			hold_d = !sel_cfg.ho_disable ||
				(sel_cfg.mode == ref_select_pkg::MODE_SHORT_HOLD);
		end else if (sel_cfg.ho_disable &&
			sel_cfg.mode == ref_select_pkg::MODE_MANUAL) begin
			hold_d = 1'b0;
		end
	end

	// Selection registers; holdover is released only by automatic mode or by mode 00 with the disable bit set
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sel_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			hold_q <= hold_d;
		end
	end
	assign selected_input = sel_q;
	assign holdover_active = hold_q;

	////////////////////////////////////////////////////////////////////////
	// Idle input gating

	// block the unselected input
	// Plain AND gating; glitch-free clock gating is the pad cell's job
	assign ref_input_0_gated = ref_input_0 & ~(sel_cfg.idle_gate & sel_q);
	assign ref_input_1_gated = ref_input_1 & ~(sel_cfg.idle_gate & ~sel_q);

endmodule : input_reference_select_control

//--- testbench/input_reference_select_control_assertions.sv
// Checker for selection, gating, holdover and divider decode
`timescale 1ns/1ps
module input_reference_select_control_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin_input_pick,
	input wire logic auto_pick,
	input wire logic ref_input_0,
	input wire logic ref_input_1,
	input wire logic ref_input_0_gated,
	input wire logic ref_input_1_gated,
	input wire logic selected_input,
	input wire logic holdover_active,
	input wire logic [5:0] monitor_div_ratio,
	input wire ref_select_pkg::sel_cfg_t sel_cfg
);
	// Delayed reset hides history from the reset itself
	logic rst_q;
	// Manual modes, pick from pin or bit
	wire man = !(sel_cfg.ho_disable && sel_cfg.mode[0]);
	always_ff @(posedge sys_clk) rst_q <= rst;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst || rst_q);
	sequence s_man_switch;
		$past(!sel_cfg.ho_disable) && $changed(selected_input);
	endsequence
	chk_gate_idle_in: assert property (sel_cfg.idle_gate |->
		!(selected_input ? ref_input_0_gated : ref_input_1_gated))
		else $error("idle input not blocked");
	chk_gate_open_both: assert property (!sel_cfg.idle_gate |->
		{ref_input_0_gated, ref_input_1_gated} == {ref_input_0, ref_input_1})
		else $error("inputs not passed");
	chk_pin_source: assert property ($past(man && !sel_cfg.src_reg) |->
		selected_input == $past(pin_input_pick)) else $error("pin ignored");
	chk_reg_source: assert property ($past(man && sel_cfg.src_reg) |->
		selected_input == $past(sel_cfg.int_sel)) else $error("bit ignored");
	chk_auto_follow: assert property ($past(!man) |->
		selected_input == $past(auto_pick)) else $error("auto choice lost");
	chk_hold_on_switch: assert property (s_man_switch |->
		holdover_active) else $error("no holdover on switch");
	chk_hold_mode_clear: assert property ($past(sel_cfg.ho_disable &&
		sel_cfg.mode == ref_select_pkg::MODE_MANUAL) |-> !holdover_active)
		else $error("holdover in mode 00");
	chk_ratio_decode: assert property (monitor_div_ratio ==
		((sel_cfg.mon_div[4] ? 6'(sel_cfg.mon_div[3:2]) + 6'h2 : 6'h1)
		<< sel_cfg.mon_div[1:0])) else $error("ratio wrong");
endmodule : input_reference_select_control_assertions

//--- testbench/input_reference_select_control_tb.sv
// Testbench for input reference selection control
`timescale 1ns/1ps
module input_reference_select_control_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	ref_select_pkg::reg_req_t reg_req = '0;
	logic pin_input_pick = 1'b0;
	logic auto_pick = 1'b0;
	logic ref_input_0, ref_input_1, reg_rvalid, man, exp;
	logic ref_input_0_gated, ref_input_1_gated, selected_input;
	logic holdover_active, monitor_tick;
	logic [7:0] reg_rdata, holdoff_count, q;
	logic [5:0] monitor_div_ratio;
	logic [1:0] holdoff_prescale, holdoff_aux;
	logic [31:0] r;
	ref_select_pkg::sel_cfg_t sel_cfg;
	int n_errors = 0;
	int tests_run = 0;
	int ticks;
	int unsigned rs = 88063;
	// Register model: reset values, writable masks, unmapped last
	int mdl [5] = '{'h00, 'h00, 'h80, 'h00, 0};
	int msk [5] = '{'hFF, 'h1D, 'hFF, 'hC3, 0};
	always #5 sys_clk = !sys_clk;
	ref_source_model ref_source_model_i (.ref_input_0(ref_input_0),
		.ref_input_1(ref_input_1));
	input_reference_select_control input_reference_select_control_i (
		.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pin_input_pick(pin_input_pick), .auto_pick(auto_pick),
		.ref_input_0(ref_input_0), .ref_input_1(ref_input_1),
		.ref_input_0_gated(ref_input_0_gated),
		.ref_input_1_gated(ref_input_1_gated),
		.selected_input(selected_input), .holdover_active(holdover_active),
		.monitor_div_ratio(monitor_div_ratio), .monitor_tick(monitor_tick),
		.sel_cfg(sel_cfg), .holdoff_count(holdoff_count),
		.holdoff_prescale(holdoff_prescale), .holdoff_aux(holdoff_aux));
	function automatic int unsigned xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : check
	// One strobe cycle; read data lands one cycle later
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) reg_req <= '{w, !w, a, d};
		@(posedge sys_clk) reg_req <= '0;
		#1 q = reg_rdata;
		// Valid pulse only answers a read, never a write
		check(reg_rvalid, !w);
	endtask : bus
	task automatic print_verdict();
		$display("Counts: run %0d, errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		#100000 n_errors++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		// Reset values, masks and an unmapped place
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'h20 + 8'(i), 8'h00);
			check(q, 8'(mdl[i]));
			bus(1'b1, 8'h20 + 8'(i), 8'hFF);
			bus(1'b0, 8'h20 + 8'(i), 8'h00);
			check(q, 8'(msk[i]));
		end
		// Hold-off fields reach their outputs after the all-ones writes
		check(holdoff_count, 8'hFF);
		check({holdoff_prescale, holdoff_aux}, 8'h0F);
		$display("Test registers done");
		// Random config and pins against the model
		repeat (60) begin
			r = xs();
			bus(1'b1, 8'h20, r[7:0]);
			bus(1'b1, 8'h21, r[15:8]);
			@(posedge sys_clk);
			pin_input_pick <= r[16];
			auto_pick <= r[17];
			repeat (2) @(posedge sys_clk);
			#1 man = !(r[1] && r[10]);
			exp = man ? (r[0] ? r[8] : r[16]) : r[17];
			check(selected_input, exp);
		end
		$display("Test selection done");
		// Mode 00 clears, then a manual switch holds
		bus(1'b1, 8'h20, 8'h03);
		bus(1'b1, 8'h21, 8'h00);
		// Holdover flag follows a new mode one cycle after the write lands
		@(posedge sys_clk);
		#1 check(holdover_active, 1'b0);
		bus(1'b1, 8'h20, 8'h01);
		bus(1'b1, 8'h21, 8'h01);
		// Switch and holdover register one cycle after the select bit
		@(posedge sys_clk);
		#1 check(holdover_active, 1'b1);
		check(selected_input, 1'b1);
		$display("Test holdover done");
		// Divide by five: 20 ticks in 100 cycles
		bus(1'b1, 8'h20, 8'hE0);
		check(monitor_div_ratio, 8'h05);
		repeat (50) @(posedge sys_clk);
		ticks = 0;
		repeat (100) begin
			@(posedge sys_clk);
			#1 ticks += monitor_tick;
		end
		check(8'(ticks), 8'h14);
		$display("Test monitor done");
		print_verdict();
	end
endmodule : input_reference_select_control_tb
bind input_reference_select_control
	input_reference_select_control_assertions chk_i (.sys_clk(sys_clk),
	.rst(rst), .pin_input_pick(pin_input_pick), .auto_pick(auto_pick),
	.ref_input_0(ref_input_0), .ref_input_1(ref_input_1),
	.ref_input_0_gated(ref_input_0_gated),
	.ref_input_1_gated(ref_input_1_gated), .selected_input(selected_input),
	.holdover_active(holdover_active), .sel_cfg(sel_cfg),
	.monitor_div_ratio(monitor_div_ratio));

//--- testbench/ref_source_model.sv
// Model of the two external reference clock sources
`timescale 1ns/1ps
module ref_source_model #(
	parameter real HALF_0 = 20.0,
	parameter real HALF_1 = 27.0
) (
	output logic ref_input_0,
	output logic ref_input_1
);
	// Free running, unrelated phases
	initial ref_input_0 = 1'b0;
	initial ref_input_1 = 1'b0;
	always #HALF_0 ref_input_0 = !ref_input_0;
	always #HALF_1 ref_input_1 = !ref_input_1;
endmodule : ref_source_model
